// ==== dmr_core.sv ====
// Overview of operation
// - A3 picks sequential or interleaved beat order
// - Burst field: fixed chop, eight, or on-the-fly
// - Sequential eight: rotate low bits, then other group
// - Interleaved eight: start column xor beat count
// - Chopped reads: one group, last four undriven
// - Writes ignore low column bits, fixed order
// - Fixed chop starts internal write two clocks early
// - On-the-fly chop write starts like eight-beat
// - DLL reset bit clears itself after use
// - Write recovery plus precharge gives precharge delay
// - Power-down DLL bit picks slow or fast exit
// - DLL off in self-refresh, back on exit
// - Driver impedance from second register bits 1,5
// - Write termination applies without nominal termination
// - Commands held additive latency before internal issue
// - Write latency is additive plus CAS write
// - CAS write latency from third register bits 3-5
`timescale 1ns/10ps
`default_nettype none
module dmr_core (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire dmr_pkg::dmr_cmd_t cmd_kind,
    input wire logic [2:0] cmd_bank,
    input wire logic [dmr_pkg::ADDR_W-1:0] cmd_addr,
    input wire logic [4:0] cas_latency,
    output logic beat_valid,
    input wire logic beat_ready,
    output logic [2:0] beat_index,
    output logic beat_drive,
    output logic beat_write,
    output logic beat_last,
    output logic internal_issue,
    output logic write_start,
    output logic dll_reset_bit,
    output logic dll_running,
    output logic dll_locked,
    output logic [1:0] drive_impedance,
    output logic [2:0] termination_sel,
    output logic termination_is_write,
    output logic [dmr_pkg::LAT_W-1:0] read_latency,
    output logic [dmr_pkg::LAT_W-1:0] write_latency,
    output logic [dmr_pkg::LAT_W-1:0] auto_precharge_delay,
    output logic slow_exit_sel
);
    import dmr_pkg::*;

    // ==========================================================
    // Helpers
    function automatic logic [LAT_W-1:0] dec_wait(input logic [LAT_W-1:0] cnt);
        return (cnt == '0) ? '0 : LAT_W'(cnt - 1'b1);
    endfunction : dec_wait

    function automatic logic [2:0] order_beat(input logic wr, input logic chop,
        input logic interleave, input logic [2:0] col, input logic [2:0] slot);
        if (wr)
            return chop ? {col[2], slot[1:0]} : slot;
        if (interleave)
            return col ^ slot;
        return {col[2] ^ slot[2], 2'(col[1:0] + slot[1:0])};
    endfunction : order_beat

    function automatic logic [LAT_W-1:0] wr_cycles(input logic [2:0] code);
        case (code)
            3'h0: return 6'h10;
            3'h1: return 6'h05;
            3'h2: return 6'h06;
            3'h3: return 6'h07;
            3'h4: return 6'h08;
            3'h5: return 6'h0a;
            3'h6: return 6'h0c;
            default: return 6'h0e;
        endcase
    endfunction : wr_cycles

    // ==========================================================
    // Mode register fields
    logic [1:0] burst_len_q;
    logic burst_type_q;
    logic [2:0] wr_code_q;
    logic pd_fast_q;
    logic dll_disable_q;
    logic [1:0] drive_q;
    logic [2:0] rtt_nom_q;
    logic [1:0] al_code_q;
    logic qoff_q;
    logic [2:0] cwl_code_q;
    logic [1:0] rtt_wr_q;
    logic cmd_take;
    logic mrs_take;

    assign cmd_take = cmd_valid && cmd_ready;
    assign mrs_take = cmd_take && (cmd_kind == CMD_MRS);

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            burst_len_q <= RST_BL;
            burst_type_q <= 1'b0;
            wr_code_q <= RST_WR;
            pd_fast_q <= 1'b0;
        end
        else if (mrs_take && cmd_bank == BANK_FIRST_MR)
        begin
            burst_len_q <= cmd_addr[MR0_BL_LSB +: 2];
            burst_type_q <= cmd_addr[MR0_BT_BIT];
            wr_code_q <= cmd_addr[MR0_WR_LSB +: 3];
            pd_fast_q <= cmd_addr[MR0_PD_BIT];
        end
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            dll_disable_q <= 1'b0;
            drive_q <= 2'h0;
            rtt_nom_q <= 3'h0;
            al_code_q <= RST_AL;
            qoff_q <= 1'b0;
        end
        else if (mrs_take && cmd_bank == BANK_SECOND_MR)
        begin
            dll_disable_q <= cmd_addr[MR1_DLL_DIS_BIT];
            drive_q <= {cmd_addr[MR1_DRV_HI_BIT], cmd_addr[MR1_DRV_LO_BIT]};
            rtt_nom_q <= {cmd_addr[MR1_RTT2_BIT], cmd_addr[MR1_RTT1_BIT],
                cmd_addr[MR1_RTT0_BIT]};
            al_code_q <= cmd_addr[MR1_AL_LSB +: 2];
            qoff_q <= cmd_addr[MR1_QOFF_BIT];
        end
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cwl_code_q <= RST_CWL;
            rtt_wr_q <= 2'h0;
        end
        else if (mrs_take && cmd_bank == BANK_THIRD_MR)
        begin
            cwl_code_q <= cmd_addr[MR2_CWL_LSB +: 3];
            rtt_wr_q <= cmd_addr[MR2_RTT_WR_LSB +: 2];
        end
    end

    // ==========================================================
    // Latencies
    logic [LAT_W-1:0] cl_val, al_val, cwl_val;

    assign cl_val = LAT_W'(cas_latency);
    assign cwl_val = LAT_W'(CWL_BASE + LAT_W'(cwl_code_q));
    assign al_val = (al_code_q == AL_CL_MINUS1) ? dec_wait(cl_val) :
        (al_code_q == AL_CL_MINUS2) ? dec_wait(dec_wait(cl_val)) : '0;

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            read_latency <= '0;
            write_latency <= '0;
            auto_precharge_delay <= '0;
            drive_impedance <= 2'h0;
            slow_exit_sel <= 1'b1;
        end
        else
        begin
            read_latency <= LAT_W'(al_val + cl_val);
            write_latency <= LAT_W'(al_val + cwl_val);
            auto_precharge_delay <= LAT_W'(wr_cycles(wr_code_q) + PRECHARGE_CYC);
            drive_impedance <= drive_q;
            slow_exit_sel <= !pd_fast_q;
        end
    end

    // ==========================================================
    // DLL reset, power state and lock
    logic in_sref_q, in_pd_q;
    logic [9:0] lock_cnt_q;

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            dll_reset_bit <= 1'b0;
        else if (mrs_take && cmd_bank == BANK_FIRST_MR)
            dll_reset_bit <= cmd_addr[MR0_DLL_RST_BIT];
        else
            dll_reset_bit <= 1'b0;
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            in_sref_q <= 1'b0;
            in_pd_q <= 1'b0;
        end
        else if (cmd_take)
        begin
            if (cmd_kind == CMD_SREF_ENTER)
                in_sref_q <= 1'b1;
            else if (cmd_kind == CMD_SREF_EXIT)
                in_sref_q <= 1'b0;
            if (cmd_kind == CMD_PD_ENTER)
                in_pd_q <= 1'b1;
            else if (cmd_kind == CMD_PD_EXIT)
                in_pd_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            dll_running <= 1'b0;
        else
            dll_running <= !dll_disable_q && !in_sref_q && !(in_pd_q && !pd_fast_q);
    end

    // Lock count restarts on each DLL reset, advances only while running
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            lock_cnt_q <= '0;
            dll_locked <= 1'b0;
        end
        else if (dll_reset_bit || !dll_running)
        begin
            lock_cnt_q <= '0;
            dll_locked <= 1'b0;
        end
        else if (lock_cnt_q != DLL_LOCK_CYC)
            lock_cnt_q <= 10'(lock_cnt_q + 1'b1);
        else
            dll_locked <= 1'b1;
    end

    // ==========================================================
    // Command sequencer
    dmr_state_t state_q;
    logic [LAT_W-1:0] wait_q;
    logic [2:0] slot_q;
    logic [2:0] col_q;
    logic is_write_q, chop_q, fixed_chop_q;
    logic gen_ready, gen_push, cmd_chop;

    assign gen_push = (state_q == ST_BURST) && gen_ready;
    assign cmd_chop = (burst_len_q == BL_FIXED_CHOP) ||
        (burst_len_q == BL_ON_THE_FLY && !cmd_addr[CHOP_SEL_BIT]);

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            col_q <= 3'h0;
            is_write_q <= 1'b0;
            chop_q <= 1'b0;
            fixed_chop_q <= 1'b0;
        end
        else if (cmd_take && (cmd_kind == CMD_READ || cmd_kind == CMD_WRITE))
        begin
            col_q <= cmd_addr[2:0];
            is_write_q <= (cmd_kind == CMD_WRITE);
            chop_q <= cmd_chop;
            fixed_chop_q <= (burst_len_q == BL_FIXED_CHOP);
        end
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_q <= ST_IDLE;
            wait_q <= '0;
            slot_q <= 3'h0;
            cmd_ready <= 1'b0;
            internal_issue <= 1'b0;
        end
        else
        begin
            internal_issue <= 1'b0;
            case (state_q)
                ST_IDLE:
                begin
                    cmd_ready <= 1'b1;
                    if (cmd_take && (cmd_kind == CMD_READ || cmd_kind == CMD_WRITE))
                    begin
                        cmd_ready <= 1'b0;
                        slot_q <= 3'h0;
                        if (al_val == '0)
                        begin
                            state_q <= ST_LAT;
                            internal_issue <= 1'b1;
                            wait_q <= dec_wait((cmd_kind == CMD_WRITE) ? cwl_val : cl_val);
                        end
                        else
                        begin
                            state_q <= ST_HOLD;
                            wait_q <= dec_wait(al_val);
                        end
                    end
                    else if (cmd_take && cmd_kind == CMD_PD_EXIT)
                    begin
                        cmd_ready <= 1'b0;
                        state_q <= ST_EXIT;
                        wait_q <= dec_wait(pd_fast_q ? FAST_EXIT_CYC : SLOW_EXIT_CYC);
                    end
                end
                ST_HOLD:
                    if (wait_q == '0)
                    begin
                        state_q <= ST_LAT;
                        internal_issue <= 1'b1;
                        wait_q <= dec_wait(is_write_q ? cwl_val : cl_val);
                    end
                    else
                        wait_q <= dec_wait(wait_q);
                ST_LAT:
                    if (wait_q == '0)
                        state_q <= ST_BURST;
                    else
                        wait_q <= dec_wait(wait_q);
                ST_BURST:
                    if (gen_push)
                    begin
                        slot_q <= 3'(slot_q + 1'b1);
                        if (slot_q == LAST_SLOT)
                        begin
                            state_q <= ST_IDLE;
                            cmd_ready <= 1'b1;
                        end
                    end
                ST_EXIT:
                    if (wait_q == '0)
                    begin
                        state_q <= ST_IDLE;
                        cmd_ready <= 1'b1;
                    end
                    else
                        wait_q <= dec_wait(wait_q);
                default:
                begin
                    state_q <= ST_IDLE;
                    cmd_ready <= 1'b0;
                end
            endcase
        end
    end

    // ==========================================================
    // Internal write start, pulled in only for fixed chop
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            write_start <= 1'b0;
        else
            write_start <= gen_push && is_write_q &&
                (slot_q == (fixed_chop_q ? WR_START_SLOT_CHOP : WR_START_SLOT_FULL));
    end

    // ==========================================================
    // Termination selection
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            termination_sel <= 3'h0;
            termination_is_write <= 1'b0;
        end
        else if (state_q == ST_BURST && is_write_q && rtt_wr_q != 2'h0)
        begin
            termination_sel <= {1'b0, rtt_wr_q};
            termination_is_write <= 1'b1;
        end
        else
        begin
            termination_sel <= rtt_nom_q;
            termination_is_write <= 1'b0;
        end
    end

    // ==========================================================
    // Beat stream into the two-entry buffer
    logic [2:0] gen_index;
    logic gen_used;
    logic [STREAM_W-1:0] out_word;

    assign gen_index = order_beat(is_write_q, chop_q, burst_type_q, col_q, slot_q);
    assign gen_used = !(chop_q && slot_q[2]) && (is_write_q || !qoff_q);

    dmr_buffer #(
        .WIDTH(STREAM_W)
    ) u_buffer (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .in_valid(state_q == ST_BURST),
        .in_ready(gen_ready),
        .in_data({is_write_q, gen_used, slot_q == LAST_SLOT, gen_index}),
        .out_valid(beat_valid),
        .out_ready(beat_ready),
        .out_data(out_word)
    );

    assign beat_write = out_word[5];
    assign beat_drive = out_word[4];
    assign beat_last = out_word[3];
    assign beat_index = out_word[2:0];
endmodule : dmr_core
`default_nettype wire

// ==== dmr_pkg.sv ====
`default_nettype none
package dmr_pkg;
    // ==========================================================
    // Command and bus widths
    localparam int ADDR_W = 16;
    localparam int LAT_W = 6;
    localparam int STREAM_W = 6;

    // ==========================================================
    // Mode register selection by bank bits
    localparam logic [2:0] BANK_FIRST_MR = 3'h0;
    localparam logic [2:0] BANK_SECOND_MR = 3'h1;
    localparam logic [2:0] BANK_THIRD_MR = 3'h2;

    // ==========================================================
    // Field positions, first_mode_register
    localparam int MR0_BL_LSB = 0;
    localparam int MR0_BT_BIT = 3;
    localparam int MR0_DLL_RST_BIT = 8;
    localparam int MR0_WR_LSB = 9;
    localparam int MR0_PD_BIT = 12;

    // Field positions, second_mode_register
    localparam int MR1_DLL_DIS_BIT = 0;
    localparam int MR1_DRV_LO_BIT = 1;
    localparam int MR1_DRV_HI_BIT = 5;
    localparam int MR1_RTT0_BIT = 2;
    localparam int MR1_RTT1_BIT = 6;
    localparam int MR1_RTT2_BIT = 9;
    localparam int MR1_AL_LSB = 3;
    localparam int MR1_QOFF_BIT = 12;

    // Field positions, third_mode_register
    localparam int MR2_CWL_LSB = 3;
    localparam int MR2_RTT_WR_LSB = 9;

    // Chop select address line on read and write commands
    localparam int CHOP_SEL_BIT = 12;

    // ==========================================================
    // Field encodings
    localparam logic [1:0] BL_FIXED_EIGHT = 2'h0;
    localparam logic [1:0] BL_ON_THE_FLY = 2'h1;
    localparam logic [1:0] BL_FIXED_CHOP = 2'h2;
    localparam logic [1:0] AL_CL_MINUS1 = 2'h1;
    localparam logic [1:0] AL_CL_MINUS2 = 2'h2;
    localparam logic [LAT_W-1:0] CWL_BASE = 6'h05;

    // ==========================================================
    // Values after reset
    localparam logic [1:0] RST_BL = 2'h0;
    localparam logic [2:0] RST_WR = 3'h1;
    localparam logic [1:0] RST_AL = 2'h0;
    localparam logic [2:0] RST_CWL = 3'h0;

    // ==========================================================
    // Burst geometry
    localparam logic [2:0] LAST_SLOT = 3'h7;
    localparam int BEATS_PER_CLK = 2;
    localparam int CHOP_PULL_IN_CLKS = 2;
    localparam logic [2:0] WR_START_SLOT_FULL = LAST_SLOT;
    localparam logic [2:0] WR_START_SLOT_CHOP =
        3'(int'(LAST_SLOT) - CHOP_PULL_IN_CLKS * BEATS_PER_CLK);

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_PS = 10000;
    localparam int FAST_EXIT_NS = 6;
    localparam int SLOW_EXIT_NS = 24;
    localparam int PRECHARGE_NS = 14;
    localparam logic [LAT_W-1:0] FAST_EXIT_CYC =
        LAT_W'((FAST_EXIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [LAT_W-1:0] SLOW_EXIT_CYC =
        LAT_W'((SLOW_EXIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [LAT_W-1:0] PRECHARGE_CYC =
        LAT_W'((PRECHARGE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [9:0] DLL_LOCK_CYC = 10'h200;

    // ==========================================================
    // Types
    typedef enum logic [3:0] {
        CMD_NOP, CMD_MRS, CMD_ACT, CMD_READ, CMD_WRITE,
        CMD_SREF_ENTER, CMD_SREF_EXIT, CMD_PD_ENTER, CMD_PD_EXIT
    } dmr_cmd_t;

    typedef enum logic [2:0] {
        ST_IDLE, ST_HOLD, ST_LAT, ST_BURST, ST_EXIT
    } dmr_state_t;
endpackage : dmr_pkg
`default_nettype wire

// ==== dmr_buffer.sv ====
`timescale 1ns/10ps
`default_nettype none
module dmr_buffer #(
    parameter int WIDTH = 6
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] head_q, head_d, tail_q, tail_d;
    logic head_v_q, head_v_d, tail_v_q, tail_v_d;
    logic push, pop;

    assign push = in_valid && in_ready;
    assign pop = head_v_q && out_ready;

    // ==========================================================
    // Two-entry shift buffer, head always feeds the output
    always_comb
    begin
        head_d = head_q;
        tail_d = tail_q;
        head_v_d = head_v_q;
        tail_v_d = tail_v_q;
        if (pop)
        begin
            head_d = tail_q;
            head_v_d = tail_v_q;
            tail_v_d = 1'b0;
        end
        if (push)
        begin
            if (!head_v_d)
            begin
                head_d = in_data;
                head_v_d = 1'b1;
            end
            else
            begin
                tail_d = in_data;
                tail_v_d = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            head_q <= '0;
            tail_q <= '0;
            head_v_q <= 1'b0;
            tail_v_q <= 1'b0;
            in_ready <= 1'b0;
        end
        else
        begin
            head_q <= head_d;
            tail_q <= tail_d;
            head_v_q <= head_v_d;
            tail_v_q <= tail_v_d;
            in_ready <= !tail_v_d;
        end
    end

    assign out_valid = head_v_q;
    assign out_data = head_q;
endmodule : dmr_buffer
`default_nettype wire

// ==== dmr_core_assertions.sv ====
`timescale 1ns/10ps
`default_nettype none
module dmr_core_checker (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire dmr_pkg::dmr_cmd_t cmd_kind,
    input wire logic [2:0] cmd_bank,
    input wire logic [dmr_pkg::ADDR_W-1:0] cmd_addr,
    input wire logic [4:0] cas_latency,
    input wire logic beat_valid,
    input wire logic beat_ready,
    input wire logic [2:0] beat_index,
    input wire logic internal_issue,
    input wire logic dll_reset_bit,
    input wire logic dll_running,
    input wire logic [1:0] drive_impedance,
    input wire logic [dmr_pkg::LAT_W-1:0] read_latency,
    input wire logic slow_exit_sel
);
    import dmr_pkg::*;
    // ==========================================================
    // Accepted command decode
    logic tk;
    logic mr0;
    logic [ADDR_W-1:0] a_q;
    assign tk = cmd_valid && cmd_ready;
    assign mr0 = tk && cmd_kind == CMD_MRS && cmd_bank == BANK_FIRST_MR;
    always_ff @(posedge core_clk)
        if (tk) a_q <= cmd_addr;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    a_ready_drop: assert property (tk && cmd_kind == CMD_READ |=> !cmd_ready)
        else $error("cmd_ready stayed high after a read");
    a_issue_now: assert property (tk && cmd_kind == CMD_READ &&
        read_latency == {1'b0, cas_latency} |=> internal_issue)
        else $error("no internal issue with zero additive latency");
    a_dll_pulse: assert property (mr0 && cmd_addr[8] |=> dll_reset_bit ##1 !dll_reset_bit)
        else $error("dll reset bit not a one cycle pulse");
    a_slow_sel: assert property (mr0 |-> ##[1:2] slow_exit_sel == !a_q[12])
        else $error("slow exit select wrong");
    a_drive_imp: assert property (tk && cmd_kind == CMD_MRS &&
        cmd_bank == BANK_SECOND_MR |-> ##[1:2] drive_impedance == {a_q[5], a_q[1]})
        else $error("driver impedance wrong");
    a_sref_off: assert property (tk && cmd_kind == CMD_SREF_ENTER |-> ##[1:2] !dll_running)
        else $error("dll kept running in self refresh");
    a_beat_hold: assert property (beat_valid && !beat_ready |=>
        beat_valid && $stable(beat_index))
        else $error("stalled beat lost");
    a_exit_fast: assert property (tk && cmd_kind == CMD_PD_EXIT && !slow_exit_sel
        |=> !cmd_ready ##[1:3] cmd_ready)
        else $error("fast exit wait wrong");
    a_exit_slow: assert property (tk && cmd_kind == CMD_PD_EXIT && slow_exit_sel
        |=> !cmd_ready [*2] ##[1:4] cmd_ready)
        else $error("slow exit wait wrong");
endmodule : dmr_core_checker
`default_nettype wire

// ==== dmr_ctl_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module dmr_ctl_model (
    input wire logic core_clk,
    input wire logic cmd_ready,
    output logic cmd_valid,
    output dmr_pkg::dmr_cmd_t cmd_kind,
    output logic [2:0] cmd_bank,
    output logic [dmr_pkg::ADDR_W-1:0] cmd_addr,
    output logic beat_ready
);
    import dmr_pkg::*;
    int stall = 0;
    logic ph = 1'b0;
    initial
    begin
        cmd_valid = 1'b0;
        cmd_kind = CMD_NOP;
        cmd_bank = 3'h0;
        cmd_addr = '0;
        beat_ready = 1'b1;
    end
    // ==========================================================
    // Beat receiver, stalls every other cycle when asked
    always @(posedge core_clk)
    begin
        ph <= ~ph;
        beat_ready <= stall == 0 || ph;
    end
    // Command held until taken, then lines show inverse
    task automatic issue(input dmr_cmd_t k, input logic [2:0] b, input logic [ADDR_W-1:0] a);
        cmd_valid <= 1'b1;
        cmd_kind <= k;
        cmd_bank <= b;
        cmd_addr <= a;
        do
        begin
            @(posedge core_clk);
        end while (!cmd_ready);
        cmd_valid <= 1'b0;
        cmd_kind <= CMD_NOP;
        cmd_bank <= ~b;
        cmd_addr <= ~a;
        @(posedge core_clk);
    endtask : issue
endmodule : dmr_ctl_model
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import dmr_pkg::*;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [4:0] cas_latency = 5'h06;
    logic cmd_valid, cmd_ready, beat_valid, beat_ready, beat_drive, beat_write, beat_last;
    logic internal_issue, write_start, dll_reset_bit, dll_running, dll_locked;
    logic termination_is_write, slow_exit_sel;
    dmr_cmd_t cmd_kind;
    logic [2:0] cmd_bank, beat_index, termination_sel;
    logic [ADDR_W-1:0] cmd_addr;
    logic [1:0] drive_impedance;
    logic [LAT_W-1:0] read_latency, write_latency, auto_precharge_delay;
    int fail_count = 0;
    int cmp_count = 0;
    int ws8, wsc, wso, wsx;
    logic [1:0] rtt_wr_e = 2'h0;
    dmr_core dut_u (.*);
    dmr_ctl_model ctl_u (.*);
    always #5 core_clk = ~core_clk;
    // ==========================================================
    // Helpers
    task automatic end_of_test;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_of_test
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        cmp_count++;
        if (s !== e)
        begin
            $display("[ERR] %s expected %h seen %h", n, e, s);
            fail_count++;
        end
    endtask : chk
    task automatic mrs(input logic [2:0] b, input logic [15:0] a);
        ctl_u.issue(CMD_MRS, b, a);
        repeat (3) @(posedge core_clk);
    endtask : mrs
    function automatic logic [15:0] mr0(input logic [1:0] bl, input logic bt);
        return {12'h160, bt, 1'b0, bl};
    endfunction : mr0
    task automatic burst(input dmr_cmd_t k, input logic [15:0] a, input logic il,
        input logic ch, output int ws);
        int n;
        int t;
        logic [2:0] e;
        n = 0;
        t = 0;
        ws = -1;
        ctl_u.issue(k, 3'h0, a);
        while (n < 8 && t < 300)
        begin
            @(posedge core_clk);
            t++;
            if (write_start)
                ws = n;
            if (beat_valid && beat_ready)
            begin
                if (k == CMD_WRITE)
                    e = ch ? {a[2], n[1:0]} : 3'(n);
                else if (il)
                    e = a[2:0] ^ 3'(n);
                else
                    e = {a[2] ^ n[2], a[1:0] + n[1:0]};
                chk("beat_drive", 8'(!(ch && n > 3)), 8'(beat_drive));
                if (!(ch && n > 3)) chk("beat_index", 8'(e), 8'(beat_index));
                chk("beat_write", 8'(k == CMD_WRITE), 8'(beat_write));
                chk("beat_last", 8'(n == 7), 8'(beat_last));
                if (n == 0 && k == CMD_WRITE)
                    chk("term_sel", 8'(rtt_wr_e), 8'(termination_sel));
                n++;
            end
        end
        chk("beats", 8'h08, 8'(n));
    endtask : burst
    // ==========================================================
    // Scenarios
    initial
    begin
        repeat (16) @(posedge core_clk);
        chk("slow_exit_sel", 8'h01, 8'(slow_exit_sel));
        reset_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        chk("read_latency", 8'h06, 8'(read_latency));
        mrs(BANK_SECOND_MR, 16'h0020);
        chk("drive_impedance", 8'h02, 8'(drive_impedance));
        mrs(BANK_FIRST_MR, 16'h1700);
        chk("slow_exit_sel", 8'h00, 8'(slow_exit_sel));
        chk("ap_delay", 8'(PRECHARGE_CYC + 6'h07), 8'(auto_precharge_delay));
        for (int i = 0; i < 700 && !dll_locked; i++) @(posedge core_clk);
        chk("dll_locked", 8'h01, 8'(dll_locked));
        ctl_u.issue(CMD_PD_ENTER, 3'h0, 16'h0000);
        ctl_u.issue(CMD_PD_EXIT, 3'h0, 16'h0000);
        ctl_u.stall = 1;
        for (int m = 0; m < 4; m++)
        begin
            mrs(BANK_FIRST_MR, mr0(BL_FIXED_EIGHT, m[1]));
            burst(CMD_READ, m[0] ? 16'h0003 : 16'h0005, m[1], 1'b0, wsx);
        end
        mrs(BANK_FIRST_MR, mr0(BL_FIXED_CHOP, 1'b0));
        burst(CMD_READ, 16'h0005, 1'b0, 1'b1, wsx);
        ctl_u.stall = 0;
        burst(CMD_WRITE, 16'h0006, 1'b0, 1'b1, wsc);
        mrs(BANK_FIRST_MR, mr0(BL_FIXED_EIGHT, 1'b0));
        burst(CMD_WRITE, 16'h0005, 1'b0, 1'b0, ws8);
        mrs(BANK_FIRST_MR, mr0(BL_ON_THE_FLY, 1'b1));
        burst(CMD_WRITE, 16'h0005, 1'b1, 1'b1, wso);
        chk("chop_pull_in", 8'h04, 8'(ws8 - wsc));
        chk("otf_write_start", 8'(ws8), 8'(wso));
        burst(CMD_READ, 16'h1003, 1'b1, 1'b0, wsx);
        burst(CMD_READ, 16'h0003, 1'b1, 1'b1, wsx);
        mrs(BANK_SECOND_MR, 16'h0028);
        chk("read_latency", 8'h0b, 8'(read_latency));
        chk("write_latency", 8'h0a, 8'(write_latency));
        mrs(BANK_THIRD_MR, 16'h0010);
        chk("write_latency", 8'h0c, 8'(write_latency));
        burst(CMD_READ, 16'h1000, 1'b1, 1'b0, wsx);
        mrs(BANK_THIRD_MR, 16'h0210);
        rtt_wr_e = 2'h1;
        burst(CMD_WRITE, 16'h1000, 1'b1, 1'b0, wsx);
        mrs(BANK_FIRST_MR, 16'h0600);
        chk("slow_exit_sel", 8'h01, 8'(slow_exit_sel));
        ctl_u.issue(CMD_PD_ENTER, 3'h0, 16'h0000);
        ctl_u.issue(CMD_PD_EXIT, 3'h0, 16'h0000);
        ctl_u.issue(CMD_SREF_ENTER, 3'h0, 16'h0000);
        ctl_u.issue(CMD_SREF_EXIT, 3'h0, 16'h0000);
        repeat (10) @(posedge core_clk);
        chk("dll_running", 8'h01, 8'(dll_running));
        end_of_test();
    end
    initial
    begin
        repeat (20000) @(posedge core_clk);
        $display("[ERR] watchdog expected done seen hang");
        fail_count++;
        end_of_test();
    end
endmodule : tb_top
bind dmr_core dmr_core_checker chk_u (.*);
`default_nettype wire
